// [rtl/bfs_pkg.sv]
// Constants shared by the buck fault and hiccup sequencer.
package bfs_pkg;

  // Clock and time base.
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SW_FREQ_HZ    = 500_000;
  localparam int unsigned SW_DIV_CYC    = CLK_HZ / SW_FREQ_HZ;
  localparam int unsigned US_DIV_CYC    = CLK_HZ / 1_000_000;

  // Fault blanking and hiccup timing.
  localparam int unsigned BLANK_US      = 20;
  localparam int unsigned BLANK_CYC     = BLANK_US * US_DIV_CYC;
  localparam int unsigned OC_BLANK_NS   = 150;
  localparam int unsigned OC_BLANK_CYC  = (OC_BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SS_SHORT_MS   = 1;
  localparam int unsigned SS_SHORT_US   = SS_SHORT_MS * 1000;
  localparam int unsigned HICCUP_MIN_MS = 4;
  localparam int unsigned HICCUP_MIN_US = HICCUP_MIN_MS * 1000;
  localparam int unsigned HICCUP_MULT   = 4;

  // Over-current counters.
  localparam int unsigned OC_TRIP_COUNT = 3;
  localparam int unsigned BACKUP_COUNT  = 7;

  // Register map, byte addresses.
  localparam logic [11:0] CTRL_ADDR     = 12'h000;
  localparam logic [11:0] SSDUR_ADDR    = 12'h004;
  localparam logic [11:0] STATUS_ADDR   = 12'h008;
  localparam logic [11:0] FAULT_ADDR    = 12'h00C;

  // Control register fields and reset values.
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_PREBIAS_BIT = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h3;
  localparam logic [15:0] SSDUR_RESET     = 16'h03E8;

  // Status register fields.
  localparam int unsigned ST_STATE_LSB  = 0;
  localparam int unsigned ST_OCCNT_LSB  = 4;
  localparam int unsigned ST_HOLD_BIT   = 6;
  localparam int unsigned ST_REL_BIT    = 7;
  localparam int unsigned ST_PINS_LSB   = 8;

  // Sticky fault register fields.
  localparam int unsigned FLT_OV_BIT    = 0;
  localparam int unsigned FLT_UV_BIT    = 1;
  localparam int unsigned FLT_OC_BIT    = 2;
  localparam int unsigned FLT_OTS_BIT   = 3;
  localparam int unsigned FLT_TSD_BIT   = 4;
  localparam int unsigned FLT_W         = 5;

  // Positions of the synchronised pin inputs.
  localparam int unsigned SI_EN         = 0;
  localparam int unsigned SI_UVLO       = 1;
  localparam int unsigned SI_OVER       = 2;
  localparam int unsigned SI_UNDER      = 3;
  localparam int unsigned SI_ABOVE      = 4;
  localparam int unsigned SI_TRIP       = 5;
  localparam int unsigned SI_LSPHASE    = 6;
  localparam int unsigned SI_OTS        = 7;
  localparam int unsigned SI_TSD        = 8;
  localparam int unsigned SI_CLAMP      = 9;
  localparam int unsigned SI_OKFLAG     = 10;
  localparam int unsigned SI_W          = 11;

  // Sequencer states.
  typedef enum logic [2:0] {
    BFS_OFF, BFS_SOFTSTART, BFS_RUN, BFS_OVFAULT, BFS_HICCUP, BFS_OTS_HOLD, BFS_TSD_HOLD
  } bfs_state_t;

endpackage

// [rtl/bfs_sequencer.sv]
// Fault, pre-bias and hiccup sequencer for a synchronous buck converter.
//
// Overview of operation
// - Pre-charged output below set point: no gate switching until feedback reaches it.
// - Pre-charged output above set point: no switching until it falls back.
// - Hiccup entry turns both drives off and pulls the good flag low.
// - Hiccup waits four soft-start durations before a new soft-start.
// - Soft-start under 1 ms gives a fixed 4 ms hiccup wait.
// - Soft-start after hiccup reacts to over-current only.
// - External over-temperature above reference stops switching, both drives off.
// - External over-temperature clearing starts a fresh soft-start automatically.
// - Over-voltage latches only after more than 20 us continuous assertion.
// - Over-voltage: upper off, lower on, good flag pulled low at once.
// - After over-voltage, hiccup starts only once feedback is under-voltage.
// - Under-voltage held over 20 us latches a fault and enters hiccup.
// - Low-side current trip sampled only 150 ns into low-side conduction.
// - After a trip, upper drive off until trip clears and next cycle.
// - Three consecutive low-side trips enter hiccup.
// - Seven clean switching cycles clear the trip counter.
// - Backup counter restarts on every trip until the third.
// - Missing trip-set resistor, seen by the clamp, selects fixed threshold.
// - Die overheat turns both drives off.
// - Die overheat pulls compensation low until release, which starts a soft-start.
// - Good flag released only inside window with no fault present.
// - Good flag pulled low on any fault or during soft-start.
// - Any soft-start lets only over-current act.
// - Soft-start begins on enable and control enable bit once the supply lockout cleared.
`timescale 1ns/100ps

module bfs_sequencer #(
  parameter int unsigned SW_DIV        = bfs_pkg::SW_DIV_CYC,
  parameter int unsigned US_DIV        = bfs_pkg::US_DIV_CYC,
  parameter int unsigned HICCUP_MIN_US = bfs_pkg::HICCUP_MIN_US
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog comparators and supply monitors, asynchronous.
  input  wire logic        enableComp,
  input  wire logic        supplyUvloOk,
  input  wire logic        feedbackOverComp,
  input  wire logic        feedbackUnderComp,
  input  wire logic        feedbackAboveSet,
  input  wire logic        lowsideCurrentTrip,
  input  wire logic        lowsidePhase,
  input  wire logic        externalOvertempInput,
  input  wire logic        dieOverheatShutdown,
  input  wire logic        tripSetClampHit,
  // Power stage and loop controls.
  output logic             upperSwitchEn,
  output logic             lowerSwitchEn,
  output logic             softStartRestart,
  output logic             softStartRun,
  output logic             compPullLow,
  output logic             fixedTripSel,
  // Open-drain good flag.
  input  wire logic        outputOkFlagIn,
  output logic             outputOkFlagOut,
  output logic             outputOkFlagOe
);
  import bfs_pkg::*;

  // Saturating blanking counter: counts while the level holds, else restarts.
  function automatic logic [11:0] holdCount(input logic [11:0] cnt, input logic lvl);
    logic [11:0] res;
    res = 12'h000;
    if (lvl) begin
      res = (cnt == 12'(BLANK_CYC)) ? cnt : cnt + 12'h001;
    end
    return res;
  endfunction

  // Two-stage synchroniser for every pin input.
  logic [SI_W-1:0] syncA_ff;
  logic [SI_W-1:0] syncB_ff;
  wire  [SI_W-1:0] pinsRaw = {outputOkFlagIn, tripSetClampHit, dieOverheatShutdown,
                              externalOvertempInput, lowsidePhase, lowsideCurrentTrip,
                              feedbackAboveSet, feedbackUnderComp, feedbackOverComp,
                              supplyUvloOk, enableComp};

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= pinsRaw;
      syncB_ff <= syncA_ff;
    end
  end

  wire enIn    = syncB_ff[SI_EN];
  wire uvloIn  = syncB_ff[SI_UVLO];
  wire overIn  = syncB_ff[SI_OVER];
  wire underIn = syncB_ff[SI_UNDER];
  wire aboveIn = syncB_ff[SI_ABOVE];
  wire tripIn  = syncB_ff[SI_TRIP];
  wire lsIn    = syncB_ff[SI_LSPHASE];
  wire otsIn   = syncB_ff[SI_OTS];
  wire tsdIn   = syncB_ff[SI_TSD];

  // Registers and state.
  bfs_state_t         state_ff;
  bfs_state_t         nxt_state;
  logic [1:0]         ctrl_ff;
  logic [15:0]        ssDur_ff;
  logic [FLT_W-1:0]   fault_ff;
  logic [31:0]        prdata_ff;
  logic [15:0]        swCnt_ff;
  logic [15:0]        usCnt_ff;
  logic [19:0]        tmr_ff;
  logic [11:0]        ovCnt_ff;
  logic [11:0]        uvCnt_ff;
  logic [4:0]         lsCnt_ff;
  logic               ocSeen_ff;
  logic               ocHold_ff;
  logic [1:0]         ocCount_ff;
  logic [2:0]         backupCnt_ff;
  logic               released_ff;
  logic               fbStart_ff;
  logic               upper_ff;
  logic               lower_ff;
  logic               restart_ff;
  logic               ssRun_ff;
  logic               compLow_ff;
  logic               clamp_ff;
  logic               okOe_ff;

  // Time base: switching-period and microsecond enables.
  wire swTick = (swCnt_ff == 16'(SW_DIV - 1));
  wire usTick = (usCnt_ff == 16'(US_DIV - 1));

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      swCnt_ff <= 16'h0000;
      usCnt_ff <= 16'h0000;
    end else begin
      swCnt_ff <= swTick ? 16'h0000 : swCnt_ff + 16'h0001;
      usCnt_ff <= usTick ? 16'h0000 : usCnt_ff + 16'h0001;
    end
  end

  // APB decode; the slave never inserts wait states.
  wire selCtrl   = (paddr[11:2] == CTRL_ADDR[11:2]);
  wire selSsDur  = (paddr[11:2] == SSDUR_ADDR[11:2]);
  wire selStatus = (paddr[11:2] == STATUS_ADDR[11:2]);
  wire selFault  = (paddr[11:2] == FAULT_ADDR[11:2]);
  wire mapped    = selCtrl | selSsDur | selStatus | selFault;
  wire apbAccess = psel & penable;
  wire apbWrite  = apbAccess & pwrite & mapped;
  wire apbSetupRd = psel & ~penable & ~pwrite;

  wire ctrlEn      = ctrl_ff[CTRL_EN_BIT];
  wire prebiasHold = ctrl_ff[CTRL_PREBIAS_BIT];

  wire [31:0] statusWord = {13'h0000, syncB_ff, released_ff, ocHold_ff,
                            ocCount_ff, 1'b0, 3'(state_ff)};
  wire [31:0] rdMux = selCtrl   ? {30'h0000_0000, ctrl_ff} :
                      selSsDur  ? {16'h0000, ssDur_ff} :
                      selStatus ? statusWord :
                      selFault  ? {27'h000_0000, fault_ff} : 32'h0000_0000;

  // Enable path and sequencer qualifiers.
  wire startOk   = enIn & uvloIn & ctrlEn;
  wire inSs      = (state_ff == BFS_SOFTSTART);
  wire switching = (inSs & released_ff) | (state_ff == BFS_RUN);
  wire fullFault = (state_ff == BFS_RUN);

  // Over- and under-voltage blanking, and temperature trips.
  wire ovTrip = (ovCnt_ff == 12'(BLANK_CYC)) & overIn & fullFault;
  wire uvTrip = (uvCnt_ff == 12'(BLANK_CYC)) & underIn & fullFault;
  wire otsTrip = otsIn & fullFault;
  wire tsdTrip = tsdIn & fullFault;

  // Low-side current trip sampling and counters.
  wire lsBlankDone = (lsCnt_ff == 5'(OC_BLANK_CYC));
  wire ocEvent  = switching & lsIn & lsBlankDone & tripIn & ~ocSeen_ff;
  wire ocThird  = ocEvent & (ocCount_ff == 2'(OC_TRIP_COUNT - 1));
  wire backupClr = swTick & (backupCnt_ff == 3'(BACKUP_COUNT - 1)) & ~ocEvent;

  // Hiccup wait length in microseconds.
  wire [19:0] hiccupWait = (ssDur_ff < 16'(SS_SHORT_US)) ? 20'(HICCUP_MIN_US) :
                           20'(ssDur_ff) * 20'(HICCUP_MULT);
  wire hiccupDone = (tmr_ff >= hiccupWait);
  wire ssDone     = released_ff & (tmr_ff >= 20'(ssDur_ff));

  // Pre-bias release: switching waits for the feedback to cross the set point.
  wire fbCrossed = (aboveIn != fbStart_ff);
  wire enterSs   = (nxt_state == BFS_SOFTSTART) & ~inSs;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      BFS_OFF: begin
        if (startOk) begin
          nxt_state = BFS_SOFTSTART;
        end
      end
      BFS_SOFTSTART: begin
        if (ocThird) begin
          nxt_state = BFS_HICCUP;
        end else if (ssDone) begin
          nxt_state = BFS_RUN;
        end
      end
      BFS_RUN: begin
        if (tsdTrip) begin
          nxt_state = BFS_TSD_HOLD;
        end else if (otsTrip) begin
          nxt_state = BFS_OTS_HOLD;
        end else if (ovTrip) begin
          nxt_state = BFS_OVFAULT;
        end else if (uvTrip | ocThird) begin
          nxt_state = BFS_HICCUP;
        end
      end
      BFS_OVFAULT: begin
        if (underIn) begin
          nxt_state = BFS_HICCUP;
        end
      end
      BFS_HICCUP: begin
        if (hiccupDone) begin
          nxt_state = BFS_SOFTSTART;
        end
      end
      BFS_OTS_HOLD: begin
        if (!otsIn) begin
          nxt_state = BFS_SOFTSTART;
        end
      end
      BFS_TSD_HOLD: begin
        if (!tsdIn) begin
          nxt_state = BFS_SOFTSTART;
        end
      end
      default: begin
        nxt_state = BFS_OFF;
      end
    endcase
    if (!startOk) begin
      nxt_state = BFS_OFF;
    end
  end

  // Next values of the registered outputs.
  wire nxtSwitching = (nxt_state == BFS_RUN) | ((nxt_state == BFS_SOFTSTART) & released_ff
                      & ~enterSs);
  wire nxtOcHold    = ocEvent | (ocHold_ff & ~(swTick & ~tripIn));
  wire nxt_upper    = nxtSwitching & ~nxtOcHold;
  wire nxt_lower    = nxtSwitching | (nxt_state == BFS_OVFAULT);
  wire windowOk     = ~overIn & ~underIn & ~otsIn & ~tsdIn;
  wire nxt_okOe     = ~((nxt_state == BFS_RUN) & windowOk & ~nxtOcHold);
  wire [FLT_W-1:0] faultSet = {tsdTrip, otsTrip, ocThird, uvTrip, ovTrip};
  wire [FLT_W-1:0] faultClr = (apbWrite & selFault) ? pwdata[FLT_W-1:0] : '0;

  // Sequencer state, timers and pre-bias tracking.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_ff    <= BFS_OFF;
      tmr_ff      <= 20'h0_0000;
      released_ff <= 1'b0;
      fbStart_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        tmr_ff <= 20'h0_0000;
      end else if (usTick && tmr_ff != 20'hF_FFFF) begin
        tmr_ff <= tmr_ff + 20'h0_0001;
      end
      if (enterSs) begin
        released_ff <= ~prebiasHold;
        fbStart_ff  <= aboveIn;
      end else if (inSs && fbCrossed) begin
        released_ff <= 1'b1;
      end
    end
  end

  // Fault blanking counters.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ovCnt_ff <= 12'h000;
      uvCnt_ff <= 12'h000;
    end else begin
      ovCnt_ff <= holdCount(ovCnt_ff, overIn);
      uvCnt_ff <= holdCount(uvCnt_ff, underIn);
    end
  end

  // Low-side blanking window and one trip per low-side period.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lsCnt_ff  <= 5'h00;
      ocSeen_ff <= 1'b0;
    end else begin
      if (!lsIn) begin
        lsCnt_ff <= 5'h00;
      end else if (!lsBlankDone) begin
        lsCnt_ff <= lsCnt_ff + 5'h01;
      end
      ocSeen_ff <= lsIn & (ocSeen_ff | ocEvent);
    end
  end

  // Trip counter, backup counter and upper-drive hold.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ocHold_ff    <= 1'b0;
      ocCount_ff   <= 2'h0;
      backupCnt_ff <= 3'h0;
    end else begin
      ocHold_ff <= nxtOcHold & switching;
      if (!switching || ocThird) begin
        ocCount_ff   <= 2'h0;
        backupCnt_ff <= 3'h0;
      end else if (ocEvent) begin
        ocCount_ff   <= ocCount_ff + 2'h1;
        backupCnt_ff <= 3'h0;
      end else if (backupClr) begin
        ocCount_ff   <= 2'h0;
        backupCnt_ff <= 3'h0;
      end else if (swTick && ocCount_ff != 2'h0) begin
        backupCnt_ff <= backupCnt_ff + 3'h1;
      end
    end
  end

  // Registered outputs toward the power stage.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      upper_ff   <= 1'b0;
      lower_ff   <= 1'b0;
      restart_ff <= 1'b0;
      ssRun_ff   <= 1'b0;
      compLow_ff <= 1'b0;
      clamp_ff   <= 1'b0;
      okOe_ff    <= 1'b1;
    end else begin
      upper_ff   <= nxt_upper;
      lower_ff   <= nxt_lower;
      restart_ff <= enterSs;
      ssRun_ff   <= (nxt_state == BFS_SOFTSTART);
      compLow_ff <= (state_ff == BFS_TSD_HOLD);
      clamp_ff   <= syncB_ff[SI_CLAMP];
      okOe_ff    <= nxt_okOe;
    end
  end

  // Software registers; a hardware set wins over a clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_ff   <= CTRL_RESET;
      ssDur_ff  <= SSDUR_RESET;
      fault_ff  <= '0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      if (apbWrite && selCtrl) begin
        ctrl_ff <= pwdata[1:0];
      end
      if (apbWrite && selSsDur) begin
        ssDur_ff <= pwdata[15:0];
      end
      fault_ff <= (fault_ff & ~faultClr) | faultSet;
      if (apbSetupRd) begin
        prdata_ff <= rdMux;
      end
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = 1'b1;
  assign pslverr          = apbAccess & ~mapped;
  assign upperSwitchEn    = upper_ff;
  assign lowerSwitchEn    = lower_ff;
  assign softStartRestart = restart_ff;
  assign softStartRun     = ssRun_ff;
  assign compPullLow      = compLow_ff;
  assign fixedTripSel     = clamp_ff;
  assign outputOkFlagOut  = 1'b0;
  assign outputOkFlagOe   = okOe_ff;

endmodule

// [test/bfs_sequencer_checker.sv]
// Port-level assertions for the buck fault and hiccup sequencer.
`timescale 1ns/100ps
module bfs_sequencer_checker (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Comparator inputs.
  input wire logic feedbackOverComp,
  input wire logic feedbackUnderComp,
  input wire logic externalOvertempInput,
  input wire logic dieOverheatShutdown,
  input wire logic tripSetClampHit,
  // Stage and flag outputs.
  input wire logic upperSwitchEn,
  input wire logic lowerSwitchEn,
  input wire logic softStartRestart,
  input wire logic softStartRun,
  input wire logic compPullLow,
  input wire logic fixedTripSel,
  input wire logic outputOkFlagOut,
  input wire logic outputOkFlagOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_TSD_OFF: assert property (
    (dieOverheatShutdown && !softStartRun)[*5] |-> !upperSwitchEn && !lowerSwitchEn)
    else $error("die overheat left a drive on");
  AST_OTS_OFF: assert property (
    (externalOvertempInput && !softStartRun)[*5] |-> !upperSwitchEn && !lowerSwitchEn)
    else $error("external overtemp left a drive on");
  AST_PULL_OFF: assert property (
    compPullLow && !softStartRun |-> !upperSwitchEn && !lowerSwitchEn)
    else $error("drive on while compensation pulled low");
  AST_PULL_RESTART: assert property (
    $fell(compPullLow) |-> softStartRun && ($past(softStartRestart) || softStartRestart))
    else $error("overheat release without soft-start");
  AST_RESTART_PULSE: assert property (
    softStartRestart |-> softStartRun ##1 !softStartRestart)
    else $error("restart pulse malformed");
  AST_SS_FLAG: assert property (
    softStartRun |-> outputOkFlagOe)
    else $error("good flag released during soft-start");
  AST_OD_LOW: assert property (
    outputOkFlagOe |-> !outputOkFlagOut)
    else $error("good flag driven high");
  AST_OK_WINDOW: assert property (
    $fell(outputOkFlagOe) |-> !$past(feedbackOverComp, 3) && !$past(feedbackUnderComp, 3))
    else $error("good flag released outside window");
  AST_FIXED_TRIP: assert property (
    tripSetClampHit[*4] |-> fixedTripSel)
    else $error("fixed threshold not selected");
  AST_NORMAL_TRIP: assert property (
    (!tripSetClampHit)[*4] |-> !fixedTripSel)
    else $error("fixed threshold selected without clamp");

  COV_RESTART: cover property (softStartRestart);
  COV_PULL: cover property (compPullLow);
  COV_RELEASE: cover property ($fell(outputOkFlagOe));
endmodule

// [test/bfs_stage_model.sv]
// Behavioural power stage and comparator bank facing the sequencer.
`timescale 1ns/100ps
module bfs_stage_model #(
  parameter int unsigned SW_DIV = 20
) (
  // Clock.
  input  wire logic       ref_clk,
  // Scenario controls.
  input  wire logic [1:0] fbLevel,
  input  wire logic       tripReq,
  input  wire logic       tripShort,
  // Sequencer side.
  input  wire logic       lowerSwitchEn,
  input  wire logic       outputOkFlagOut,
  input  wire logic       outputOkFlagOe,
  output logic            feedbackOverComp,
  output logic            feedbackUnderComp,
  output logic            feedbackAboveSet,
  output logic            lowsidePhase,
  output logic            lowsideCurrentTrip,
  output logic            outputOkFlagIn
);
  int unsigned phaseCnt = 0;
  logic        armed    = 1'h0;
  logic        firing   = 1'h0;

  // Level 0 under, 1 below set point, 2 above set point, 3 over.
  assign feedbackOverComp   = fbLevel == 2'h3;
  assign feedbackUnderComp  = fbLevel == 2'h0;
  assign feedbackAboveSet   = fbLevel >= 2'h2;
  assign lowsidePhase       = lowerSwitchEn && phaseCnt >= 3;
  // A short trip ends inside the blanking interval.
  assign lowsideCurrentTrip = firing && lowsidePhase && (!tripShort || phaseCnt < 8);
  // The flag line has a pull-up when nobody pulls it down.
  assign outputOkFlagIn     = outputOkFlagOe ? outputOkFlagOut : 1'h1;

  // One requested trip covers one whole low-side conduction period.
  always_ff @(posedge ref_clk) begin
    phaseCnt <= (phaseCnt == SW_DIV - 1) ? 0 : phaseCnt + 1;
    if (tripReq) begin
      armed <= 1'h1;
    end
    if (phaseCnt == 2 && armed && lowerSwitchEn) begin
      firing <= 1'h1;
      armed  <= 1'h0;
    end
    if (phaseCnt == SW_DIV - 1) begin
      firing <= 1'h0;
    end
  end
endmodule

// [test/tb_bfs_sequencer.sv]
// Self-checking bench for the buck fault and hiccup sequencer.
`timescale 1ns/100ps
module tb_bfs_sequencer;
  import bfs_pkg::*;
  localparam int unsigned SW = 20;
  localparam int unsigned US = 4;
  localparam int unsigned HMIN = 40;
  logic ref_clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, upperSwitchEn, lowerSwitchEn, softStartRestart;
  logic softStartRun, compPullLow, fixedTripSel, outputOkFlagOut, outputOkFlagOe;
  logic enableComp = 1'h0, supplyUvloOk = 1'h0, externalOvertempInput = 1'h0;
  logic dieOverheatShutdown = 1'h0, tripSetClampHit = 1'h0, tripReq = 1'h0, tripShort = 1'h0;
  logic feedbackOverComp, feedbackUnderComp, feedbackAboveSet, lowsideCurrentTrip;
  logic lowsidePhase, outputOkFlagIn;
  logic [1:0] fb = 2'h1;
  int miscompares = 0, compares = 0, cyc = 0;

  bfs_sequencer #(.SW_DIV(SW), .US_DIV(US), .HICCUP_MIN_US(HMIN)) i_bfs_sequencer (
    .ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .enableComp, .supplyUvloOk, .feedbackOverComp, .feedbackUnderComp, .feedbackAboveSet,
    .lowsideCurrentTrip, .lowsidePhase, .externalOvertempInput, .dieOverheatShutdown,
    .tripSetClampHit, .upperSwitchEn, .lowerSwitchEn, .softStartRestart, .softStartRun,
    .compPullLow, .fixedTripSel, .outputOkFlagIn, .outputOkFlagOut, .outputOkFlagOe);
  bfs_stage_model #(.SW_DIV(SW)) i_bfs_stage_model (
    .ref_clk, .fbLevel(fb), .tripReq, .tripShort, .lowerSwitchEn, .outputOkFlagOut,
    .outputOkFlagOe, .feedbackOverComp, .feedbackUnderComp, .feedbackAboveSet,
    .lowsidePhase, .lowsideCurrentTrip, .outputOkFlagIn);

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One APB transfer followed by one idle cycle.
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic waitSt(logic [2:0] s, int lim);
    int n = 0;
    apb(1'h0, STATUS_ADDR, 0);
    while (rd[2:0] !== s && n < lim) begin
      apb(1'h0, STATUS_ADDR, 0);
      n += 3;
    end
    chk("state", rd[2:0], s);
  endtask

  task automatic sc_regs();
    apb(1'h0, CTRL_ADDR, 0);
    chk("ctrl", rd, 32'h0000_0003);
    apb(1'h0, SSDUR_ADDR, 0);
    chk("ssdur", rd, 32'h0000_03E8);
    apb(1'h0, 12'h010, 0);
    chk("unmappedRd", rd, 32'h0000_0000);
    chk("unmappedErr", err, 1'h1);
    chk("resetFlag", {upperSwitchEn, outputOkFlagOe}, 2'h1);
    tripSetClampHit <= 1'h1;
    tick(6);
    chk("fixedTrip", fixedTripSel, 1'h1);
    tripSetClampHit <= 1'h0;
    apb(1'h1, SSDUR_ADDR, 32'h0000_0014);
  endtask

  task automatic sc_start(logic [1:0] lvl0, logic [1:0] lvl1);
    fb <= lvl0;
    supplyUvloOk <= 1'h0;
    enableComp <= 1'h1;
    tick(20);
    chk("noUvlo", softStartRun, 1'h0);
    supplyUvloOk <= 1'h1;
    waitSt(3'h1, 20);
    tick(40);
    chk("preBias", {upperSwitchEn, lowerSwitchEn}, 2'h0);
    fb <= lvl1;
    waitSt(3'h2, 200);
    tick(4);
    chk("run", {upperSwitchEn, lowerSwitchEn, outputOkFlagIn}, 3'h7);
  endtask

  task automatic sc_uv(int ss);
    int n = 0;
    int t0;
    int w = (ss < SS_SHORT_US) ? HMIN * US : ss * HICCUP_MULT * US;
    apb(1'h1, CTRL_ADDR, 32'h0000_0001);
    apb(1'h1, SSDUR_ADDR, ss);
    fb <= 2'h0;
    tick(1990);
    chk("uvBlank", upperSwitchEn, 1'h1);
    while (upperSwitchEn && n++ < 60) tick(1);
    chk("hicOff", {upperSwitchEn, lowerSwitchEn, outputOkFlagOe}, 3'h1);
    t0 = cyc;
    fb <= 2'h1;
    while (softStartRestart !== 1'h1 && cyc - t0 < w + 50) tick(1);
    chk("hicWait", (cyc - t0 + 4 >= w) && (cyc - t0 <= w + 4), 1'h1);
    fb <= 2'h0;
    externalOvertempInput <= 1'h1;
    tick(110);
    apb(1'h0, STATUS_ADDR, 0);
    chk("ssMask", rd[2:0], 3'h1);
    fb <= 2'h1;
    externalOvertempInput <= 1'h0;
    waitSt(3'h2, ss * US + 100);
    apb(1'h0, FAULT_ADDR, 0);
    chk("uvSticky", rd[1], 1'h1);
    apb(1'h1, FAULT_ADDR, 32'h0000_001F);
    apb(1'h0, FAULT_ADDR, 0);
    chk("w1c", rd, 32'h0000_0000);
  endtask

  task automatic sc_ov();
    int n = 0;
    apb(1'h1, SSDUR_ADDR, 32'h0000_0014);
    fb <= 2'h3;
    tick(1990);
    fb <= 2'h1;
    tick(10);
    chk("ovShort", {upperSwitchEn, lowerSwitchEn}, 2'h3);
    fb <= 2'h3;
    tick(1990);
    chk("ovBlank", upperSwitchEn, 1'h1);
    while (upperSwitchEn && n++ < 60) tick(1);
    chk("ovDrive", {upperSwitchEn, lowerSwitchEn, outputOkFlagOe}, 3'h3);
    tick(100);
    chk("ovWait", lowerSwitchEn, 1'h1);
    fb <= 2'h0;
    tick(6);
    chk("ovHic", {upperSwitchEn, lowerSwitchEn}, 2'h0);
    fb <= 2'h1;
    waitSt(3'h2, 600);
  endtask

  task automatic sc_oc();
    int n = 0;
    tripShort <= 1'h1;
    tripReq <= 1'h1;
    tick(1);
    tripReq <= 1'h0;
    tick(3 * SW);
    apb(1'h0, STATUS_ADDR, 0);
    chk("ocBlank", rd[5:4], 2'h0);
    tripShort <= 1'h0;
    tripReq <= 1'h1;
    tick(1);
    tripReq <= 1'h0;
    while (upperSwitchEn && n++ < 3 * SW) tick(1);
    chk("ocHold", upperSwitchEn, 1'h0);
    n = 0;
    while (!upperSwitchEn && n++ < 2 * SW + 10) tick(1);
    chk("ocResume", upperSwitchEn, 1'h1);
    apb(1'h0, STATUS_ADDR, 0);
    chk("ocCount", rd[5:4], 2'h1);
    tick(8 * SW + 10);
    apb(1'h0, STATUS_ADDR, 0);
    chk("ocBackup", rd[5:4], 2'h0);
    repeat (3) begin
      tripReq <= 1'h1;
      tick(1);
      tripReq <= 1'h0;
      tick(4 * SW);
    end
    chk("ocHic", {upperSwitchEn, lowerSwitchEn}, 2'h0);
    apb(1'h0, FAULT_ADDR, 0);
    chk("ocSticky", rd[2], 1'h1);
    waitSt(3'h2, 600);
  endtask

  task automatic sc_hold(logic die);
    int n = 0;
    if (die) dieOverheatShutdown <= 1'h1;
    else externalOvertempInput <= 1'h1;
    tick(6);
    chk("holdOff", {upperSwitchEn, lowerSwitchEn, outputOkFlagOe}, 3'h1);
    chk("pullLow", compPullLow, die);
    if (die) dieOverheatShutdown <= 1'h0;
    else externalOvertempInput <= 1'h0;
    while (softStartRestart !== 1'h1 && n++ < 8) tick(1);
    chk("holdRestart", softStartRestart, 1'h1);
    waitSt(3'h2, 400);
  endtask

  initial begin
    tick(3);
    rstn <= 1'h1;
    sc_regs();
    sc_start(2'h1, 2'h2);
    enableComp <= 1'h0;
    waitSt(3'h0, 20);
    sc_start(2'h2, 2'h1);
    sc_uv(60);
    sc_uv(1000);
    sc_ov();
    sc_oc();
    sc_hold(1'h0);
    sc_hold(1'h1);
    wrap_up();
  end

  initial begin
    #500_000;
    miscompares++;
    wrap_up();
  end
endmodule

bind bfs_sequencer bfs_sequencer_checker i_bfs_sequencer_checker (
  .ref_clk, .rstn, .feedbackOverComp, .feedbackUnderComp, .externalOvertempInput,
  .dieOverheatShutdown, .tripSetClampHit, .upperSwitchEn, .lowerSwitchEn, .softStartRestart,
  .softStartRun, .compPullLow, .fixedTripSel, .outputOkFlagOut, .outputOkFlagOe);
